// ==== pkg/issue_timing_pkg.sv ====
// constants and types for the integer pipeline issue-timing controller
package issue_timing_pkg;

  localparam int CNT_W = 4;

  typedef enum logic [4:0] {
    CLS_NONE = 5'h00,
    CLS_HALFWORD_SIGNED_MULTIPLY = 5'h01,
    CLS_HALFWORD_MULTIPLY_ACCUMULATE = 5'h02,
    CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE = 5'h03,
    CLS_WORD_BY_HALFWORD_MULTIPLY = 5'h04,
    CLS_WORD_BY_HALFWORD_ACCUMULATE = 5'h05,
    CLS_WORD_MULTIPLY = 5'h06,
    CLS_LONG_MULTIPLY = 5'h07,
    CLS_BRANCH = 5'h08,
    CLS_STATUS_READ = 5'h09,
    CLS_STATUS_WRITE_FLAGS = 5'h0a,
    CLS_STATUS_WRITE_FULL = 5'h0b,
    CLS_SAVED_STATUS_WRITE = 5'h0c,
    CLS_SOFTWARE_INTERRUPT = 5'h0d,
    CLS_LOAD = 5'h0e,
    CLS_STORE = 5'h0f
  } instr_class_type;

  typedef enum logic [2:0] {
    BR_PLAIN = 3'h0,
    BR_WITH_LINK = 3'h1,
    BR_EXCHANGE = 3'h2,
    BR_LINK_EXCHANGE_REG = 3'h3,
    BR_LINK_EXCHANGE_IMM = 3'h4,
    BR_STATE_SWITCH = 3'h5
  } branch_kind_type;

  // cycle figures, all in core clock cycles
  localparam logic [CNT_W-1:0] CYC_0 = 4'h0;
  localparam logic [CNT_W-1:0] CYC_1 = 4'h1;
  localparam logic [CNT_W-1:0] CYC_2 = 4'h2;
  localparam logic [CNT_W-1:0] CYC_3 = 4'h3;
  localparam logic [CNT_W-1:0] CYC_4 = 4'h4;
  localparam logic [CNT_W-1:0] CYC_5 = 4'h5;
  localparam logic [CNT_W-1:0] CYC_7 = 4'h7;
  localparam logic [CNT_W-1:0] CYC_9 = 4'h9;

  localparam logic [CNT_W-1:0] BRANCH_REFILL_CYC = CYC_5;
  localparam logic [CNT_W-1:0] BRANCH_FLUSHED_CYC = CYC_3;
  localparam logic [CNT_W-1:0] LINK_FOLDED_CYC = CYC_1;
  localparam logic [CNT_W-1:0] LOAD_DATA_EXTRA_CYC = CYC_1;

  localparam logic [4:0] SHIFT_ZERO = 5'h00;
  localparam logic [4:0] SHIFT_TWO = 5'h02;

  // event timer indices
  localparam int EV_LO = 0;
  localparam int EV_HI = 1;
  localparam int EV_FLAGS = 2;
  localparam int EV_BASE = 3;
  localparam int EV_LOAD = 4;
  localparam int EV_NUM = 5;

endpackage : issue_timing_pkg

// ==== rtl/event_countdown.sv ====
// one result-availability timer: pulses when its latency has elapsed
`timescale 1ns/1ps
module event_countdown
  import issue_timing_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] latency_i,
  output logic pending_o,
  output logic done_o
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic done_reg;
  logic done_next;

  // an earlier event about to fire still fires when a new one is loaded
  always_comb
  begin
    done_next = (count_reg == CYC_1) || (load_i && (latency_i == CYC_1));
    if (load_i && (latency_i != CYC_0))
    begin
      count_next = latency_i - CYC_1;
    end
    else if (count_reg != CYC_0)
    begin
      count_next = count_reg - CYC_1;
    end
    else
    begin
      count_next = CYC_0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      count_reg <= CYC_0;
      done_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      done_reg <= done_next;
    end
  end

  assign pending_o = (count_reg != CYC_0);
  assign done_o = done_reg;

endmodule : event_countdown

// ==== rtl/issue_timing_ctrl.sv ====
// issue and result-latency controller for the integer pipeline
`timescale 1ns/1ps
module issue_timing_ctrl
  import issue_timing_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic issue_valid_i,
  input wire instr_class_type instr_class_i,
  input wire logic cond_pass_i,
  input wire logic set_flags_i,
  input wire logic scaled_offset_i,
  input wire logic offset_subtract_i,
  input wire logic [4:0] shift_amount_i,
  input wire logic pre_indexed_i,
  input wire logic base_writeback_i,
  input wire logic pc_dest_i,
  input wire branch_kind_type branch_kind_i,
  input wire logic branch_conditional_i,
  input wire logic branch_backward_i,
  input wire logic predict_enable_i,
  input wire logic prefetch_flushed_i,
  input wire logic dep_result_i,
  input wire logic dep_flags_i,
  input wire logic dep_base_i,
  input wire logic load_store_pipe_empty_i,
  output logic issue_ready_o,
  output logic interlock_o,
  output logic drain_wait_o,
  output logic [CNT_W-1:0] exec_cycles_o,
  output logic exec_busy_o,
  output logic predict_taken_o,
  output logic mispredict_o,
  output logic result_lo_o,
  output logic result_hi_o,
  output logic flags_ready_o,
  output logic base_ready_o,
  output logic load_data_o
);

  logic [CNT_W-1:0] exec_cyc;
  logic [CNT_W-1:0] lat [EV_NUM];
  logic needs_drain;
  logic scaled_slow;
  logic predictable;
  logic predicted_taken;
  logic accept;
  logic [EV_NUM-1:0] ev_pending;
  logic [EV_NUM-1:0] ev_done;
  logic [EV_NUM-1:0] ev_load;
  logic [CNT_W-1:0] branch_cyc;
  logic result_pending;
  logic flags_pending;
  logic base_pending;

  // registered state: execute countdown, cost and branch outcome
  logic [CNT_W-1:0] busy_reg;
  logic [CNT_W-1:0] busy_next;
  logic [CNT_W-1:0] cost_reg;
  logic [CNT_W-1:0] cost_next;
  logic pred_reg;
  logic pred_next;
  logic mispred_reg;
  logic mispred_next;

  // shifts the address adder folds in need no extra cycles
  // optimised scaled forms
  assign scaled_slow = scaled_offset_i && !(
    (!offset_subtract_i && (shift_amount_i == SHIFT_ZERO || shift_amount_i == SHIFT_TWO)) ||
    (offset_subtract_i && shift_amount_i == SHIFT_ZERO));

  assign predictable = predict_enable_i && (branch_kind_i == BR_PLAIN ||
    branch_kind_i == BR_WITH_LINK || branch_kind_i == BR_LINK_EXCHANGE_IMM);
  // forward conditional branches are guessed not taken
  assign predicted_taken = !branch_conditional_i || branch_backward_i;

  // decode of execute cycles and latencies; zero latency means no event
  always_comb
  begin
    exec_cyc = CYC_1;
    needs_drain = 1'b0;
    for (int i = 0; i < EV_NUM; i++)
    begin
      lat[i] = CYC_0;
    end
    case (instr_class_i)
      CLS_HALFWORD_SIGNED_MULTIPLY, CLS_WORD_BY_HALFWORD_MULTIPLY:
      begin
        exec_cyc = CYC_1;
        lat[EV_LO] = CYC_2;
      end
      CLS_HALFWORD_MULTIPLY_ACCUMULATE, CLS_WORD_BY_HALFWORD_ACCUMULATE:
      begin
        exec_cyc = CYC_2;
        lat[EV_LO] = CYC_2;
      end
      CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE:
      begin
        exec_cyc = CYC_2;
        lat[EV_LO] = CYC_2;
        lat[EV_HI] = CYC_2 + CYC_1;
      end
      // word multiply, flags add two cycles
      CLS_WORD_MULTIPLY:
      begin
        exec_cyc = set_flags_i ? CYC_4 : CYC_2;
        lat[EV_LO] = CYC_3;
        lat[EV_FLAGS] = set_flags_i ? CYC_4 : CYC_0;
        // fail column is two cycles, flags or not
        if (!cond_pass_i)
        begin
          exec_cyc = CYC_2;
        end
      end
      CLS_LONG_MULTIPLY:
      begin
        exec_cyc = set_flags_i ? CYC_5 : CYC_3;
        lat[EV_LO] = CYC_3;
        lat[EV_HI] = CYC_3 + CYC_1;
        lat[EV_FLAGS] = set_flags_i ? CYC_5 : CYC_0;
        // flag forms sit in execute while the flags are formed
        if (!cond_pass_i)
        begin
          exec_cyc = CYC_2;
        end
      end
      // branch cost from its own decode
      CLS_BRANCH:
      begin
        exec_cyc = branch_cyc;
      end
      CLS_STATUS_READ:
      begin
        exec_cyc = CYC_1;
        lat[EV_LO] = CYC_1;
      end
      CLS_STATUS_WRITE_FLAGS:
      begin
        exec_cyc = CYC_1;
        lat[EV_FLAGS] = CYC_1;
      end
      // a passing full status write waits for an empty load/store pipe
      CLS_STATUS_WRITE_FULL:
      begin
        exec_cyc = cond_pass_i ? CYC_5 : CYC_1;
        needs_drain = cond_pass_i;
        lat[EV_FLAGS] = CYC_5;
      end
      CLS_SAVED_STATUS_WRITE:
      begin
        exec_cyc = cond_pass_i ? CYC_4 : CYC_2;
      end
      CLS_SOFTWARE_INTERRUPT:
      begin
        exec_cyc = cond_pass_i ? CYC_5 : CYC_2;
      end
      CLS_LOAD, CLS_STORE:
      begin
        exec_cyc = scaled_slow ? (cond_pass_i ? CYC_3 : CYC_2) : CYC_1;
        if (instr_class_i == CLS_LOAD && pc_dest_i)
        begin
          exec_cyc = cond_pass_i ? (scaled_slow ? CYC_9 : CYC_7) : CYC_2;
        end
        if (base_writeback_i)
        begin
          lat[EV_BASE] = (scaled_slow && pre_indexed_i) ? CYC_3 : CYC_1;
        end
        // load data one cycle after last execute
        if (instr_class_i == CLS_LOAD && !pc_dest_i)
        begin
          lat[EV_LOAD] = exec_cyc + LOAD_DATA_EXTRA_CYC;
        end
      end
      default:
      begin
        // unlisted classes behave as one-cycle instructions
        exec_cyc = CYC_1;
      end
    endcase
  end

  // branch cost; mispredicted forms pay the refill, other not-taken forms the fail figure of their kind
  always_comb
  begin
    if (predictable && (predicted_taken == cond_pass_i))
    begin
      if (!cond_pass_i)
      begin
        branch_cyc = (branch_kind_i == BR_PLAIN) ? CYC_1 : CYC_2;
      end
      else if (branch_kind_i == BR_PLAIN)
      begin
        branch_cyc = prefetch_flushed_i ? BRANCH_FLUSHED_CYC : CYC_0;
      end
      else
      begin
        branch_cyc = prefetch_flushed_i ? BRANCH_FLUSHED_CYC : LINK_FOLDED_CYC;
      end
    end
    else if (predictable)
    begin
      branch_cyc = BRANCH_REFILL_CYC;
    end
    else
    begin
      branch_cyc = cond_pass_i ? BRANCH_REFILL_CYC :
        ((branch_kind_i == BR_PLAIN) ? CYC_1 : CYC_2);
    end
  end

  // hold a dependent instruction until its producer's latency elapses
  assign result_pending = ev_pending[EV_LO] || ev_pending[EV_HI] || ev_pending[EV_LOAD];
  assign flags_pending = ev_pending[EV_FLAGS];
  assign base_pending = ev_pending[EV_BASE];
  // an operand the offered instruction does not read never stalls it
  assign interlock_o = issue_valid_i && ((dep_result_i && result_pending) ||
    (dep_flags_i && flags_pending) || (dep_base_i && base_pending));
  // limitation: a slow load/store pipe stretches this wait
  // drain wait
  assign drain_wait_o = issue_valid_i && (busy_reg == CYC_0) && needs_drain &&
    !load_store_pipe_empty_i;
  // best case only: no cache miss or conflict stall modelled
  assign issue_ready_o = (busy_reg == CYC_0) && !interlock_o && !drain_wait_o;
  // a take is one edge with valid and ready both high
  assign accept = issue_valid_i && issue_ready_o;
  assign exec_busy_o = (busy_reg != CYC_0);

  // one timer per result kind, so a newer producer takes over its timer
  // one timer per result event
  genvar g;
  generate
    for (g = 0; g < EV_NUM; g++)
    begin : g_event
      // failed instructions raise no result events
      assign ev_load[g] = accept && cond_pass_i && (lat[g] != CYC_0);
      event_countdown event_countdown_inst (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .load_i(ev_load[g]),
        .latency_i(lat[g]),
        .pending_o(ev_pending[g]),
        .done_o(ev_done[g])
      );
    end
  endgenerate

  always_comb
  begin
    busy_next = (busy_reg != CYC_0) ? busy_reg - CYC_1 : CYC_0;
    cost_next = cost_reg;
    pred_next = pred_reg;
    mispred_next = 1'b0;
    if (accept)
    begin
      // the issue cycle itself counts as the first execute cycle
      busy_next = (exec_cyc != CYC_0) ? exec_cyc - CYC_1 : CYC_0;
      cost_next = exec_cyc;
      pred_next = (instr_class_i == CLS_BRANCH) && predictable && predicted_taken;
      mispred_next = (instr_class_i == CLS_BRANCH) && predictable &&
        (predicted_taken != cond_pass_i);
    end
  end

  // registered so the cost and prediction stand until the next take
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      busy_reg <= CYC_0;
      cost_reg <= CYC_0;
      pred_reg <= 1'b0;
      mispred_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= busy_next;
      cost_reg <= cost_next;
      pred_reg <= pred_next;
      mispred_reg <= mispred_next;
    end
  end

  // event pulses come straight from the timer flip-flops
  assign exec_cycles_o = cost_reg;
  assign predict_taken_o = pred_reg;
  assign mispredict_o = mispred_reg;
  assign result_lo_o = ev_done[EV_LO];
  assign result_hi_o = ev_done[EV_HI];
  assign flags_ready_o = ev_done[EV_FLAGS];
  assign base_ready_o = ev_done[EV_BASE];
  assign load_data_o = ev_done[EV_LOAD];

endmodule : issue_timing_ctrl

// ==== sim/issue_timing_ctrl_props.sv ====
// concurrent checks on the issue-timing controller ports
`timescale 1ns/1ps
module issue_timing_props
  import issue_timing_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic issue_valid_i,
  input wire instr_class_type instr_class_i,
  input wire logic cond_pass_i,
  input wire logic set_flags_i,
  input wire logic scaled_offset_i,
  input wire logic pc_dest_i,
  input wire branch_kind_type branch_kind_i,
  input wire logic branch_conditional_i,
  input wire logic branch_backward_i,
  input wire logic predict_enable_i,
  input wire logic load_store_pipe_empty_i,
  input wire logic issue_ready_o,
  input wire logic exec_busy_o,
  input wire logic [CNT_W-1:0] exec_cycles_o,
  input wire logic predict_taken_o,
  input wire logic result_lo_o,
  input wire logic result_hi_o,
  input wire logic flags_ready_o,
  input wire logic load_data_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic take;
  assign take = issue_valid_i && issue_ready_o;
  sequence take_of(instr_class_type c);
    take && instr_class_i == c && cond_pass_i;
  endsequence
  sequence long_words;
    result_lo_o ##1 result_hi_o;
  endsequence
  long_order_a: assert property (take_of(CLS_LONG_MULTIPLY) |-> ##3 long_words)
    else $error("long multiply words late");
  half_mul_a: assert property (take_of(CLS_HALFWORD_SIGNED_MULTIPLY) |-> ##2 result_lo_o)
    else $error("halfword result late");
  half_long_a: assert property (take_of(CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE) |-> ##2 long_words)
    else $error("halfword long words late");
  word_flags_a: assert property (take_of(CLS_WORD_MULTIPLY) ##0 set_flags_i |->
    ##3 result_lo_o ##1 flags_ready_o) else $error("word multiply flags late");
  long_busy_a: assert property (take_of(CLS_LONG_MULTIPLY) ##0 set_flags_i |=>
    exec_busy_o [*4] ##1 (!exec_busy_o && flags_ready_o)) else $error("long flag hold wrong");
  swi_cost_a: assert property (take && instr_class_i == CLS_SOFTWARE_INTERRUPT |=>
    exec_cycles_o == ($past(cond_pass_i) ? CYC_5 : CYC_2)) else $error("interrupt cost wrong");
  saved_cost_a: assert property (take && instr_class_i == CLS_SAVED_STATUS_WRITE |=>
    exec_cycles_o == ($past(cond_pass_i) ? CYC_4 : CYC_2)) else $error("saved write cost wrong");
  drain_hold_a: assert property (issue_valid_i && instr_class_i == CLS_STATUS_WRITE_FULL
    && cond_pass_i && !load_store_pipe_empty_i |-> !issue_ready_o) else $error("no drain wait");
  load_data_a: assert property (take_of(CLS_LOAD) ##0 (!scaled_offset_i && !pc_dest_i)
    |-> ##2 load_data_o) else $error("load data late");
  predict_dir_a: assert property (take && instr_class_i == CLS_BRANCH && predict_enable_i
    && branch_kind_i == BR_PLAIN |=> predict_taken_o ==
    ($past(branch_backward_i) || !$past(branch_conditional_i))) else $error("bad prediction");
  fail_quiet_a: assert property (take && !cond_pass_i |-> ##1 !flags_ready_o [*2])
    else $error("failed instruction set flags");
endmodule : issue_timing_props

bind issue_timing_ctrl issue_timing_props issue_timing_props_inst (.*);

// ==== sim/issue_timing_ctrl_tb.sv ====
// self-checking random bench for the issue-timing controller
`timescale 1ns/1ps
module issue_timing_ctrl_tb;
  import issue_timing_pkg::*;
  logic clock_i = 0, srst_i = 1, issue_valid_i = 0, cond_pass_i = 0, set_flags_i = 0;
  logic scaled_offset_i = 0, offset_subtract_i = 0, pre_indexed_i = 0, base_writeback_i = 0;
  logic pc_dest_i = 0, branch_conditional_i = 0, branch_backward_i = 0, predict_enable_i = 0;
  logic prefetch_flushed_i = 0, dep_result_i = 0, dep_flags_i = 0, dep_base_i = 0;
  logic load_store_pipe_empty_i = 1, pred, mis;
  logic [4:0] shift_amount_i = 5'h00;
  instr_class_type instr_class_i = CLS_NONE;
  branch_kind_type branch_kind_i = BR_PLAIN;
  logic issue_ready_o, interlock_o, drain_wait_o, exec_busy_o, predict_taken_o, mispredict_o;
  logic result_lo_o, result_hi_o, flags_ready_o, base_ready_o, load_data_o;
  logic [CNT_W-1:0] exec_cycles_o, cost;
  logic [CNT_W-1:0] lat [5];
  logic [CNT_W-1:0] seen [5];
  int seed = 74042, fails = 0, checked = 0, n, cyc = 0;
  always #25 clock_i = ~clock_i;
  // pipe stays busy for stretches so full status writes must wait
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    load_store_pipe_empty_i <= (cyc % 7) > 2;
  end
  issue_timing_ctrl issue_timing_ctrl_inst (.*);
  task automatic check(string what, logic [CNT_W-1:0] got, logic [CNT_W-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic issue_wait(output int waited, input logic keep);
    logic dw;
    issue_valid_i <= 1'b1;
    for (waited = 1; waited < 40; waited++)
    begin
      @(posedge clock_i);
      dw = instr_class_i == CLS_STATUS_WRITE_FULL && cond_pass_i && !load_store_pipe_empty_i;
      check("drain wait", {3'h0, drain_wait_o}, {3'h0, dw});
      // only the directed dependant waits, for the word multiply's latency of three
      check("interlock", {3'h0, interlock_o}, {3'h0, dep_result_i && waited < 3});
      if (issue_ready_o === 1'b1)
        break;
    end
    if (waited == 40)
    begin
      fails++;
      close_out();
    end
    if (instr_class_i == CLS_STATUS_WRITE_FULL && cond_pass_i)
      check("drain", {3'h0, load_store_pipe_empty_i}, 4'h1);
    if (!keep)
      issue_valid_i <= 1'b0;
  endtask : issue_wait
  task automatic work_out();
    logic slow, ls, pcl, plain;
    logic [19:0] e;
    slow = scaled_offset_i && shift_amount_i != 5'h00
      && (offset_subtract_i || shift_amount_i != 5'h02);
    ls = instr_class_i inside {CLS_LOAD, CLS_STORE};
    pcl = pc_dest_i && instr_class_i == CLS_LOAD;
    plain = branch_kind_i == BR_PLAIN;
    pred = predict_enable_i && branch_kind_i inside {BR_PLAIN, BR_WITH_LINK, BR_LINK_EXCHANGE_IMM};
    mis = pred && instr_class_i == CLS_BRANCH
      && (!branch_conditional_i || branch_backward_i) != cond_pass_i;
    pred = pred && (!branch_conditional_i || branch_backward_i);
    // packed as pass, fail, low word, high word, flags
    case (instr_class_i)
      CLS_HALFWORD_SIGNED_MULTIPLY, CLS_WORD_BY_HALFWORD_MULTIPLY: e = 20'h11200;
      CLS_HALFWORD_MULTIPLY_ACCUMULATE, CLS_WORD_BY_HALFWORD_ACCUMULATE: e = 20'h22200;
      CLS_SIGNED_LONG_MULTIPLY_ACCUMULATE: e = 20'h22230;
      CLS_WORD_MULTIPLY: e = set_flags_i ? 20'h42304 : 20'h22300;
      CLS_LONG_MULTIPLY: e = set_flags_i ? 20'h52345 : 20'h32340;
      CLS_STATUS_READ: e = 20'h11100;
      CLS_STATUS_WRITE_FLAGS: e = 20'h11001;
      CLS_STATUS_WRITE_FULL: e = 20'h51005;
      CLS_SAVED_STATUS_WRITE: e = 20'h42000;
      CLS_SOFTWARE_INTERRUPT: e = 20'h52000;
      default: e = {pcl ? (slow ? 4'h9 : 4'h7) : (slow ? 4'h3 : 4'h1),
        (pcl || slow) ? 4'h2 : 4'h1, 12'h000};
    endcase
    cost = cond_pass_i ? e[19:16] : e[15:12];
    // 4'hf marks a cost left open, not compared
    if (instr_class_i == CLS_BRANCH)
      cost = cond_pass_i ? (pred ? (prefetch_flushed_i ? 4'h3 : {3'h0, !plain}) : 4'h5)
        : (pred ? ((plain && branch_conditional_i) ? 4'h5 : 4'hf) : (plain ? 4'h1 : 4'h2));
    lat = '{default: 4'h0};
    if (cond_pass_i)
    begin
      {lat[0], lat[1], lat[2]} = e[11:0];
      lat[3] = (ls && base_writeback_i) ? ((slow && pre_indexed_i) ? 4'h3 : 4'h1) : 4'h0;
      lat[4] = (instr_class_i == CLS_LOAD && !pcl) ? cost + 4'h1 : 4'h0;
    end
  endtask : work_out
  task automatic watch();
    logic [4:0] p;
    work_out();
    seen = '{default: 4'h0};
    for (int k = 1; k <= 10; k++)
    begin
      @(posedge clock_i);
      if (k == 1 && cost != 4'hf)
        check("cost", exec_cycles_o, cost);
      if (k == 1 && instr_class_i == CLS_BRANCH)
        check("predict", {3'h0, predict_taken_o}, {3'h0, pred});
      if (k <= 2)
        check("mispredict", {3'h0, mispredict_o}, {3'h0, mis && k == 1});
      p = {load_data_o, base_ready_o, flags_ready_o, result_hi_o, result_lo_o};
      for (int j = 0; j < 5; j++)
        if (p[j] === 1'b1 && seen[j] == 4'h0)
          seen[j] = 4'(k);
    end
    for (int j = 0; j < 5; j++)
      check("event", seen[j], lat[j]);
  endtask : watch
  task automatic rand_instr();
    logic [31:0] r;
    r = $random(seed);
    instr_class_i <= instr_class_type'(5'h01 + 5'(r[7:0] % 15));
    cond_pass_i <= r[8] | r[9];
    set_flags_i <= r[10];
    scaled_offset_i <= r[11];
    offset_subtract_i <= r[12];
    shift_amount_i <= {3'h0, r[14:13]};
    pre_indexed_i <= r[15];
    base_writeback_i <= r[16];
    pc_dest_i <= r[17] & r[18];
    branch_kind_i <= branch_kind_type'(3'(r[22:19] % 6));
    branch_conditional_i <= r[23];
    branch_backward_i <= r[24];
    predict_enable_i <= r[25];
    prefetch_flushed_i <= r[26];
  endtask : rand_instr
  initial
  begin
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    instr_class_i <= CLS_WORD_MULTIPLY;
    cond_pass_i <= 1'b1;
    issue_wait(n, 1'b1);
    instr_class_i <= CLS_STATUS_READ;
    dep_result_i <= 1'b1;
    issue_wait(n, 1'b0);
    check("dep wait", 4'(n), 4'h3);
    dep_result_i <= 1'b0;
    instr_class_i <= CLS_LONG_MULTIPLY;
    set_flags_i <= 1'b1;
    @(posedge clock_i);
    issue_wait(n, 1'b0);
    watch();
    repeat (400)
    begin
      @(posedge clock_i);
      rand_instr();
      issue_wait(n, 1'b0);
      watch();
    end
    close_out();
  end
endmodule : issue_timing_ctrl_tb
